// >>> design/dcd_addr_step.sv
// next address of one source or destination pointer
// assumes the caller loads the result only when a unit has been moved
`timescale 1ns/1ps
`include "dcd_defines.svh"

module dcd_addr_step #(
  parameter int W = 16
) (
  // current pointer and its setup
  input logic [W-1:0] addr,
  input logic [1:0] mode,
  input logic wide,
  // pointer after one unit
  output logic [W-1:0] next_addr
);

  logic [W-1:0] step;

  // one for bytes, two for words
  assign step = wide ? W'(`DCD_STEP_WORD) : W'(`DCD_STEP_BYTE);

  // fixed, increment, otherwise decrement
  always_comb begin
    if (mode == `DCD_AM_FIXED) begin
      next_addr = addr;
    end else if (mode == `DCD_AM_INC) begin
      next_addr = addr + step;
    end else begin
      next_addr = addr - step;
    end
  end

endmodule : dcd_addr_step

// >>> design/dcd_defines.svh
// named constants of the two-channel sfr/ram copy engine
// assumes inclusion by every file that names one of these constants
`ifndef DCD_DEFINES_SVH
`define DCD_DEFINES_SVH

// widths
`define DCD_AXI_AW 18
`define DCD_IDX_W 16
`define DCD_CNT_W 10
`define DCD_TRG_W 5

// register indices, byte address is four times the index
`define DCD_IDX_MODE0 16'hf700
`define DCD_IDX_CNT0 16'hf702
`define DCD_IDX_SRC0 16'hf704
`define DCD_IDX_DST0 16'hf706
`define DCD_IDX_MODE1 16'hf708
`define DCD_IDX_CNT1 16'hf70a
`define DCD_IDX_SRC1 16'hf70c
`define DCD_IDX_DST1 16'hf70e
`define DCD_IDX_EN 16'hf720
`define DCD_IDX_STAT 16'hf722
`define DCD_IDX_CLR 16'hf724
`define DCD_IDX_CH_BIT 3

// mode register fields
`define DCD_MODE_STRG 15
`define DCD_MODE_TRG_HI 12
`define DCD_MODE_TRG_LO 8
`define DCD_MODE_DS 4
`define DCD_MODE_DAMD_HI 3
`define DCD_MODE_DAMD_LO 2
`define DCD_MODE_SAMD_HI 1
`define DCD_MODE_SAMD_LO 0

// enable, status and clear fields
`define DCD_EN_LO 0
`define DCD_EN_LOCK 7
`define DCD_STAT_DONE_LO 0
`define DCD_STAT_RUN_LO 8
`define DCD_CLR_LO 0

// addressing modes, 10 and 11 both decrement
`define DCD_AM_FIXED 2'b00
`define DCD_AM_INC 2'b01
`define DCD_STEP_BYTE 16'h0001
`define DCD_STEP_WORD 16'h0002
`define DCD_EVEN_MASK 16'hfffe

// triggers: bit k of the request vector is trigger code k
`define DCD_TRIG_MASK 32'hffff03fe

// counts and bus answers
`define DCD_CNT_ONE 10'h001
`define DCD_RESP_OKAY 2'b00
`define DCD_RESP_SLVERR 2'b10

`endif

// >>> design/dcd_pkg.sv
// types of the two-channel sfr/ram copy engine
// assumes dcd_defines.svh is on the include path
`include "dcd_defines.svh"

package dcd_pkg;

  // engine sequence, one-hot
  typedef enum logic [2:0] {
    DCD_ST_IDLE = 3'b001,
    DCD_ST_READ = 3'b010,
    DCD_ST_WRITE = 3'b100
  } dcd_fsm_t;

  // one channel's programmed and running state
  typedef struct packed {
    logic [`DCD_TRG_W-1:0] trig;
    logic wide;
    logic [1:0] dst_mode;
    logic [1:0] src_mode;
    logic [`DCD_CNT_W-1:0] count;
    logic [15:0] src;
    logic [15:0] dst;
    logic en;
    logic done;
    logic pend;
  } dcd_chan_t;

  // axi4-lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [`DCD_AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`DCD_AXI_AW-1:0] araddr;
    logic rready;
  } dcd_axi_req_t;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dcd_axi_rsp_t;

  // data bus access of the engine
  typedef struct packed {
    logic req;
    logic we;
    logic wide;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dcd_mem_t;

  // whole state of the top module
  typedef struct packed {
    dcd_chan_t [1:0] ch;
    logic lock;
    logic owner_vld;
    logic owner;
    dcd_fsm_t fsm;
    logic act;
    logic [15:0] data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } dcd_state_t;

endpackage : dcd_pkg

// >>> design/dcd_top.sv
// two-channel copy engine between peripheral registers and ram, axi4-lite slave
// assumes one clock, a data bus answering reads in the cycle of the request,
// and a cpu busy input that holds the engine off the bus
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "dcd_defines.svh"

module dcd_top (
  // clock and reset
  input logic REF_CLK,
  input logic RST,
  // register bus
  input dcd_pkg::dcd_axi_req_t AXI_REQ,
  output dcd_pkg::dcd_axi_rsp_t AXI_RSP,
  // peripheral requests, bit k is trigger code k
  input logic [31:0] HW_REQ,
  // data bus shared with the cpu
  input logic CPU_BUSY,
  input logic [15:0] MEM_RDATA,
  output dcd_pkg::dcd_mem_t MEM,
  // completion event
  output logic XFER_DONE_IRQ
);
  import dcd_pkg::*;

  dcd_state_t s_reg;
  dcd_state_t s_next;
  logic wr_go;
  logic rd_go;
  logic [`DCD_IDX_W-1:0] wi;
  logic [`DCD_IDX_W-1:0] ri;
  logic wc;
  logic rc;
  logic [15:0] wv;
  logic [1:0] done_set;
  logic [1:0] elig;
  logic [31:0] trig_ok;
  logic [15:0] src_step [2];
  logic [15:0] dst_step [2];
  logic act_en;
  logic [`DCD_CNT_W-1:0] cur_cnt;
  logic wr_grant;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] dcd_merge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
    logic [15:0] m;
    m = {{8{st[1]}}, {8{st[0]}}};
    return (old & ~m) | (wd[15:0] & m);
  endfunction : dcd_merge

  // mode register image, request bit always reads zero
  function automatic logic [15:0] dcd_mode_word(input dcd_chan_t c);
    logic [15:0] v;
    v = '0;
    v[`DCD_MODE_TRG_HI:`DCD_MODE_TRG_LO] = c.trig;
    v[`DCD_MODE_DS] = c.wide;
    v[`DCD_MODE_DAMD_HI:`DCD_MODE_DAMD_LO] = c.dst_mode;
    v[`DCD_MODE_SAMD_HI:`DCD_MODE_SAMD_LO] = c.src_mode;
    return v;
  endfunction : dcd_mode_word

  // bus decode helpers
  assign wr_go = AXI_REQ.awvalid && AXI_REQ.wvalid && !s_reg.bvalid;
  assign rd_go = AXI_REQ.arvalid && !s_reg.rvalid;
  assign wi = AXI_REQ.awaddr[`DCD_AXI_AW-1:2];
  assign ri = AXI_REQ.araddr[`DCD_AXI_AW-1:2];
  assign wc = wi[`DCD_IDX_CH_BIT];
  assign rc = ri[`DCD_IDX_CH_BIT];
  assign trig_ok = HW_REQ & `DCD_TRIG_MASK;

  // active channel view
  assign act_en = s_reg.ch[s_reg.act].en;
  assign cur_cnt = s_reg.ch[s_reg.act].count;
  assign wr_grant = (s_reg.fsm == DCD_ST_WRITE) && !CPU_BUSY && act_en;

  // per-channel pointer steppers and eligibility
  for (genvar g = 0; g < 2; g++) begin : g_chan
    dcd_addr_step #(.W(16)) u_src (
      .addr(s_reg.ch[g].src),
      .mode(s_reg.ch[g].src_mode),
      .wide(s_reg.ch[g].wide),
      .next_addr(src_step[g])
    );
    dcd_addr_step #(.W(16)) u_dst (
      .addr(s_reg.ch[g].dst),
      .mode(s_reg.ch[g].dst_mode),
      .wide(s_reg.ch[g].wide),
      .next_addr(dst_step[g])
    );
    assign elig[g] = s_reg.ch[g].pend && s_reg.ch[g].en &&
                     (!(s_reg.lock && s_reg.owner_vld) || s_reg.owner == 1'(g));
  end

  // next state: engine, register writes, register reads, request latch
  always_comb begin
    s_next = s_reg;
    s_next.irq = 1'b0;
    done_set = 2'b00;
    wv = '0;
    if (s_reg.bvalid && AXI_REQ.bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && AXI_REQ.rready) begin
      s_next.rvalid = 1'b0;
    end
    // read unit then write unit, cpu first
    unique case (s_reg.fsm)
      DCD_ST_IDLE: begin
        if (elig[0] || elig[1]) begin
          s_next.act = !elig[0];
          s_next.fsm = DCD_ST_READ;
          if (s_reg.lock) begin
            s_next.owner_vld = 1'b1;
            s_next.owner = !elig[0];
          end
        end
      end
      DCD_ST_READ: begin
        if (!act_en) begin
          s_next.fsm = DCD_ST_IDLE;
        end else if (!CPU_BUSY) begin
          s_next.data = MEM_RDATA;
          s_next.fsm = DCD_ST_WRITE;
        end
      end
      DCD_ST_WRITE: begin
        if (!act_en) begin
          s_next.fsm = DCD_ST_IDLE;
        end else if (!CPU_BUSY) begin
          s_next.fsm = DCD_ST_IDLE;
          s_next.ch[s_reg.act].count = cur_cnt - `DCD_CNT_ONE;
          s_next.ch[s_reg.act].src = src_step[s_reg.act];
          s_next.ch[s_reg.act].dst = dst_step[s_reg.act];
          s_next.ch[s_reg.act].pend = 1'b0;
          if (cur_cnt == `DCD_CNT_ONE) begin
            s_next.ch[s_reg.act].en = 1'b0;
            s_next.ch[s_reg.act].done = 1'b1;
            done_set[s_reg.act] = 1'b1;
            s_next.irq = 1'b1;
            s_next.owner_vld = 1'b0;
          end
        end
      end
      default: begin
        s_next.fsm = DCD_ST_IDLE;
      end
    endcase
    // register writes
    if (wr_go) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = `DCD_RESP_OKAY;
      case (wi)
        `DCD_IDX_MODE0, `DCD_IDX_MODE1: begin
          wv = dcd_merge(dcd_mode_word(s_reg.ch[wc]), AXI_REQ.wdata, AXI_REQ.wstrb);
          if (!s_reg.ch[wc].en) begin
            s_next.ch[wc].trig = wv[`DCD_MODE_TRG_HI:`DCD_MODE_TRG_LO];
            s_next.ch[wc].wide = wv[`DCD_MODE_DS];
            s_next.ch[wc].dst_mode = wv[`DCD_MODE_DAMD_HI:`DCD_MODE_DAMD_LO];
            s_next.ch[wc].src_mode = wv[`DCD_MODE_SAMD_HI:`DCD_MODE_SAMD_LO];
          end
          if (AXI_REQ.wstrb[1] && AXI_REQ.wdata[`DCD_MODE_STRG] && s_reg.ch[wc].en &&
              !(s_next.lock && s_next.owner_vld && s_next.owner != wc)) begin
            s_next.ch[wc].pend = 1'b1;
          end
        end
        `DCD_IDX_CNT0, `DCD_IDX_CNT1: begin
          wv = dcd_merge({6'h00, s_reg.ch[wc].count}, AXI_REQ.wdata, AXI_REQ.wstrb);
          if (!s_reg.ch[wc].en) begin
            s_next.ch[wc].count = wv[`DCD_CNT_W-1:0];
          end
        end
        `DCD_IDX_SRC0, `DCD_IDX_SRC1: begin
          if (!s_reg.ch[wc].en) begin
            s_next.ch[wc].src = dcd_merge(s_reg.ch[wc].src, AXI_REQ.wdata, AXI_REQ.wstrb);
          end
        end
        `DCD_IDX_DST0, `DCD_IDX_DST1: begin
          if (!s_reg.ch[wc].en) begin
            s_next.ch[wc].dst = dcd_merge(s_reg.ch[wc].dst, AXI_REQ.wdata, AXI_REQ.wstrb);
          end
        end
        `DCD_IDX_EN: begin
          if (AXI_REQ.wstrb[0]) begin
            if (!s_reg.ch[0].en && !s_reg.ch[1].en) begin
              s_next.lock = AXI_REQ.wdata[`DCD_EN_LOCK];
            end
            for (int i = 0; i < 2; i++) begin
              s_next.ch[i].en = AXI_REQ.wdata[`DCD_EN_LO + i] && !s_next.ch[i].done;
            end
          end
        end
        `DCD_IDX_CLR: begin
          for (int i = 0; i < 2; i++) begin
            if (AXI_REQ.wstrb[0] && AXI_REQ.wdata[`DCD_CLR_LO + i] && !done_set[i]) begin
              s_next.ch[i].done = 1'b0;
            end
          end
        end
        `DCD_IDX_STAT: begin
          s_next.bresp = `DCD_RESP_OKAY;
        end
        default: begin
          s_next.bresp = `DCD_RESP_SLVERR;
        end
      endcase
    end
    // register reads, upper half always zero
    if (rd_go) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `DCD_RESP_OKAY;
      s_next.rdata = '0;
      case (ri)
        `DCD_IDX_MODE0, `DCD_IDX_MODE1: begin
          s_next.rdata[15:0] = dcd_mode_word(s_reg.ch[rc]);
        end
        `DCD_IDX_CNT0, `DCD_IDX_CNT1: begin
          s_next.rdata[`DCD_CNT_W-1:0] = s_reg.ch[rc].count;
        end
        `DCD_IDX_SRC0, `DCD_IDX_SRC1: begin
          s_next.rdata[15:0] = s_reg.ch[rc].src;
        end
        `DCD_IDX_DST0, `DCD_IDX_DST1: begin
          s_next.rdata[15:0] = s_reg.ch[rc].dst;
        end
        `DCD_IDX_EN: begin
          s_next.rdata[`DCD_EN_LOCK] = s_reg.lock;
          s_next.rdata[`DCD_EN_LO + 1] = s_reg.ch[1].en;
          s_next.rdata[`DCD_EN_LO] = s_reg.ch[0].en;
        end
        `DCD_IDX_STAT: begin
          s_next.rdata[`DCD_STAT_RUN_LO + 1] = s_reg.lock && s_reg.owner_vld && s_reg.owner;
          s_next.rdata[`DCD_STAT_RUN_LO] = s_reg.lock && s_reg.owner_vld && !s_reg.owner;
          s_next.rdata[`DCD_STAT_DONE_LO + 1] = s_reg.ch[1].done;
          s_next.rdata[`DCD_STAT_DONE_LO] = s_reg.ch[0].done;
        end
        `DCD_IDX_CLR: begin
          s_next.rresp = `DCD_RESP_OKAY;
        end
        default: begin
          s_next.rresp = `DCD_RESP_SLVERR;
        end
      endcase
    end
    // lock released when its owner is disabled
    if (s_next.owner_vld && !s_next.ch[s_next.owner].en) begin
      s_next.owner_vld = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (!s_next.ch[i].en) begin
        s_next.ch[i].pend = 1'b0;
      end else if (trig_ok[s_reg.ch[i].trig] &&
                   !(s_next.lock && s_next.owner_vld && s_next.owner != 1'(i))) begin
        s_next.ch[i].pend = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_reg <= '0;
      s_reg.fsm <= DCD_ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign AXI_RSP.awready = wr_go;
  assign AXI_RSP.wready = wr_go;
  assign AXI_RSP.bvalid = s_reg.bvalid;
  assign AXI_RSP.bresp = s_reg.bresp;
  assign AXI_RSP.arready = rd_go;
  assign AXI_RSP.rvalid = s_reg.rvalid;
  assign AXI_RSP.rdata = s_reg.rdata;
  assign AXI_RSP.rresp = s_reg.rresp;
  assign XFER_DONE_IRQ = s_reg.irq;

  // bus access, word units on even addresses
  always_comb begin
    MEM.req = ((s_reg.fsm == DCD_ST_READ) || (s_reg.fsm == DCD_ST_WRITE)) && act_en;
    MEM.we = (s_reg.fsm == DCD_ST_WRITE) && act_en;
    MEM.wide = s_reg.ch[s_reg.act].wide;
    MEM.addr = (s_reg.fsm == DCD_ST_WRITE) ? s_reg.ch[s_reg.act].dst : s_reg.ch[s_reg.act].src;
    if (MEM.wide) begin
      MEM.addr = MEM.addr & `DCD_EVEN_MASK;
    end
    MEM.wdata = s_reg.data;
  end

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_rd_grant;
    (s_reg.fsm == DCD_ST_READ) && !CPU_BUSY && act_en;
  endsequence
  sequence s_wr_grant;
    (s_reg.fsm == DCD_ST_WRITE) && !CPU_BUSY && act_en;
  endsequence

  two_cycle_unit_a: assert property (s_rd_grant ##1 s_wr_grant |=> s_reg.fsm == DCD_ST_IDLE)
    else $error("unit did not finish after two granted cycles");
  cpu_first_a: assert property ((s_reg.fsm == DCD_ST_READ) && CPU_BUSY && act_en |=>
                                s_reg.fsm == DCD_ST_READ && $stable(s_reg.data))
    else $error("engine moved while cpu held the bus");
  irq_on_last_a: assert property (wr_grant && cur_cnt == `DCD_CNT_ONE |=>
                                  XFER_DONE_IRQ && cur_cnt == '0 && !act_en && s_reg.ch[s_reg.act].done)
    else $error("last unit did not complete the channel");
  count_step_a: assert property (wr_grant && cur_cnt != `DCD_CNT_ONE |=>
                                 !XFER_DONE_IRQ && cur_cnt == $past(cur_cnt) - `DCD_CNT_ONE)
    else $error("count did not drop by one");
  done_blocks_en_a: assert property (s_reg.ch[0].done |-> !s_reg.ch[0].en)
    else $error("channel 0 enabled with done flag set");
  ch0_priority_a: assert property ((s_reg.fsm == DCD_ST_IDLE) && elig[0] && elig[1] |=>
                                   s_reg.fsm == DCD_ST_READ && !s_reg.act)
    else $error("channel 1 served ahead of channel 0");
  count_held_a: assert property (wr_go && s_reg.ch[0].en && (s_reg.fsm == DCD_ST_IDLE) &&
                                 (wi == `DCD_IDX_CNT0) |=> $stable(s_reg.ch[0].count))
    else $error("count written while enabled");
  word_even_a: assert property (MEM.req && MEM.wide |-> !MEM.addr[0])
    else $error("word access on odd address");
  lock_ignore_a: assert property (s_reg.lock && s_reg.owner_vld && !s_reg.owner && !s_reg.ch[1].pend
                                  |=> !s_reg.ch[1].pend)
    else $error("locked engine latched the other channel");
  src_inc_a: assert property (wr_grant && s_reg.ch[s_reg.act].src_mode == `DCD_AM_INC &&
                              s_reg.ch[s_reg.act].wide |=>
                              s_reg.ch[s_reg.act].src == $past(s_reg.ch[s_reg.act].src) + `DCD_STEP_WORD)
    else $error("word increment did not step by two");

endmodule : dcd_top

// >>> tb/dcd_mem_model.sv
// data bus partner: memory answering in the granted read cycle, cpu stealing cycles
// assumes the engine bus view arrives as the package struct
`timescale 1ns/1ps

module dcd_mem_model (
  // clock and reset
  input logic clk,
  input logic rst,
  // engine side
  input dcd_pkg::dcd_mem_t mem,
  input logic busy_en,
  // cpu and memory answers
  output logic cpu_busy,
  output logic [15:0] rdata
);
  import dcd_pkg::*;
  logic [15:0] pat;

  // cpu owns the bus about one cycle in three
  // cpu served first
  always @(posedge clk) begin
    cpu_busy <= !rst && busy_en && ($urandom_range(2) == 0);
  end

  assign pat = mem.addr ^ 16'h5a5a;
  // bytes on both lanes; inverted data outside a granted read
  assign rdata = (mem.req && !mem.we && !cpu_busy) ? (mem.wide ? pat : {pat[7:0], pat[7:0]}) : ~pat;
endmodule : dcd_mem_model

// >>> tb/tb_dual_channel_sfr_ram_dma.sv
// self-checking bench of the two-channel copy engine
// assumes dcd_pkg, dcd_defines.svh and the data bus partner model
`timescale 1ns/1ps
`include "dcd_defines.svh"

module tb_dual_channel_sfr_ram_dma;
  import dcd_pkg::*;
  logic ref_clk, rst, busy_en, cpu_busy, irq;
  dcd_axi_req_t req;
  dcd_axi_rsp_t rsp;
  logic [31:0] hw_req, rd;
  logic [15:0] mem_rdata;
  dcd_mem_t mem;
  logic [1:0] rs;
  int failures, checks;
  int cyc = 0;
  int irq_n = 0;
  logic [31:0] wq [$];
  logic [15:0] regs [10] = '{`DCD_IDX_MODE0, `DCD_IDX_CNT0, `DCD_IDX_SRC0, `DCD_IDX_DST0, `DCD_IDX_MODE1,
    `DCD_IDX_CNT1, `DCD_IDX_SRC1, `DCD_IDX_DST1, `DCD_IDX_EN, `DCD_IDX_STAT};

  dcd_top dut (.REF_CLK(ref_clk), .RST(rst), .AXI_REQ(req), .AXI_RSP(rsp), .HW_REQ(hw_req),
    .CPU_BUSY(cpu_busy), .MEM_RDATA(mem_rdata), .MEM(mem), .XFER_DONE_IRQ(irq));
  dcd_mem_model partner (.clk(ref_clk), .rst(rst), .mem(mem), .busy_en(busy_en),
    .cpu_busy(cpu_busy), .rdata(mem_rdata));

  // 10 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // granted writes, done pulses, hang limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (mem.req === 1'b1 && mem.we === 1'b1 && cpu_busy === 1'b0) wq.push_back({mem.addr, mem.wdata});
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (cyc == 40000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // address and data offered together, released when taken
  task automatic axi_wr(input logic [15:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'h3;
    do begin @(negedge ref_clk); n++; end while (rsp.awready !== 1'b1 && n < 100);
    @(posedge ref_clk);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do begin @(negedge ref_clk); n++; end while (rsp.bvalid !== 1'b1 && n < 100);
    rs = rsp.bresp;
    @(posedge ref_clk);
    if (n > 99) failures++;
  endtask : axi_wr

  task automatic axi_rd(input logic [15:0] idx);
    int n;
    n = 0;
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    do begin @(negedge ref_clk); n++; end while (rsp.arready !== 1'b1 && n < 100);
    @(posedge ref_clk);
    req.arvalid <= 1'b0;
    do begin @(negedge ref_clk); n++; end while (rsp.rvalid !== 1'b1 && n < 100);
    rd = rsp.rdata;
    rs = rsp.rresp;
    @(posedge ref_clk);
    if (n > 99) failures++;
  endtask : axi_rd

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
    axi_rd(idx);
    chk({30'h0, rs}, {30'h0, er}, "read resp");
    chk(rd, exp, "read data");
  endtask : rd_chk

  // pointer after k units: fixed, up, or down; word units even
  function automatic logic [15:0] exp_addr(input logic [15:0] b, input logic [1:0] md, input logic w, input int k);
    logic [15:0] off, a;
    off = (w ? 16'h0002 : 16'h0001) * 16'(k);
    a = (md == 2'b00) ? b : (md == 2'b01) ? b + off : b - off;
    return w ? (a & `DCD_EVEN_MASK) : a;
  endfunction : exp_addr

  task automatic cfg(input bit ch, input logic [4:0] trg, input logic [4:0] szmd, input logic [9:0] cnt,
      input logic [15:0] src, input logic [15:0] dst);
    logic [15:0] b;
    b = ch ? 16'h0008 : 16'h0000;
    axi_wr(`DCD_IDX_MODE0 + b, {3'b000, trg, 3'b000, szmd});
    axi_wr(`DCD_IDX_CNT0 + b, {6'h00, cnt});
    axi_wr(`DCD_IDX_SRC0 + b, src);
    axi_wr(`DCD_IDX_DST0 + b, dst);
  endtask : cfg

  // one full count on a channel, by hardware or software requests
  task automatic run_xfer(input bit ch, input logic [4:0] trg, input logic [4:0] szmd, input logic [9:0] cnt,
      input logic [15:0] src, input logic [15:0] dst, input bit sw);
    int n, i0, w;
    logic [15:0] b, m, ebit;
    b = ch ? 16'h0008 : 16'h0000;
    ebit = ch ? 16'h0002 : 16'h0001;
    n = (cnt == 10'h000) ? 1024 : int'(cnt);
    m = szmd[4] ? 16'hffff : 16'h00ff;
    cfg(ch, trg, szmd, cnt, src, dst);
    wq.delete();
    i0 = irq_n;
    axi_wr(`DCD_IDX_EN, ebit);
    if (sw) begin
      for (int k = 0; k < n; k++) begin
        axi_wr(`DCD_IDX_MODE0 + b, {3'b100, trg, 3'b000, szmd});
        for (w = 0; w < 200 && wq.size() <= k; w++) @(posedge ref_clk);
      end
    end else hw_req <= 32'h1 << trg;
    for (w = 0; w < 9000 && irq_n == i0; w++) @(posedge ref_clk);
    hw_req <= 32'h0;
    chk(32'(wq.size()), 32'(n), "unit count");
    for (int k = 0; k < n; k++) begin
      chk({wq[k][31:16], wq[k][15:0] & m}, {exp_addr(dst, szmd[3:2], szmd[4], k),
        (exp_addr(src, szmd[1:0], szmd[4], k) ^ 16'h5a5a) & m}, "unit");
    end
    chk(32'(irq_n - i0), 32'h1, "done pulse");
    rd_chk(`DCD_IDX_CNT0 + b, 32'h0, 2'b00);
    rd_chk(`DCD_IDX_MODE0 + b, {19'h0, trg, 3'b000, szmd}, 2'b00);
    rd_chk(`DCD_IDX_STAT, {16'h0, ebit}, 2'b00);
    axi_wr(`DCD_IDX_EN, ebit);
    rd_chk(`DCD_IDX_EN, 32'h0, 2'b00);
    axi_wr(`DCD_IDX_CLR, ebit);
    rd_chk(`DCD_IDX_STAT, 32'h0, 2'b00);
  endtask : run_xfer

  initial begin
    rst = 1'b1;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    hw_req = 32'h0;
    busy_en = 1'b0;
    failures = 0;
    checks = 0;
    void'($urandom(32'h3f55));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (regs[i]) rd_chk(regs[i], 32'h0, 2'b00);
    rd_chk(16'hf710, 32'h0, 2'b10);
    axi_wr(16'hf710, 16'hffff);
    chk({30'h0, rs}, 32'h2, "unmapped write");
    // unused trigger code never moves data; count locked while enabled
    cfg(1'b0, 5'b01010, 5'b00000, 10'd7, 16'h0010, 16'h0020);
    axi_wr(`DCD_IDX_EN, 16'h0001);
    hw_req <= 32'h0000_0400;
    repeat (20) @(posedge ref_clk);
    hw_req <= 32'h0;
    chk(32'(wq.size()), 32'h0, "unused trigger");
    axi_wr(`DCD_IDX_CNT0, 16'h0003);
    rd_chk(`DCD_IDX_CNT0, 32'h7, 2'b00);
    // disable early, reload before reuse
    axi_wr(`DCD_IDX_EN, 16'h0000);
    busy_en <= 1'b1;
    for (int c = 1; c < 32; c++) begin
      if (c < 10 || c > 15) run_xfer(c[0], c[4:0], 5'($urandom), 10'($urandom_range(4, 1)),
        16'($urandom), 16'($urandom), 1'b0);
    end
    run_xfer(1'b0, 5'd31, 5'b10101, 10'h000, 16'h0401, 16'h0800, 1'b0);
    run_xfer(1'b1, 5'd0, 5'b01010, 10'd3, 16'h0300, 16'h0500, 1'b1);
    // both channels on one trigger at once
    cfg(1'b0, 5'd1, 5'b00000, 10'd1, 16'h0100, 16'h0200);
    cfg(1'b1, 5'd1, 5'b00000, 10'd1, 16'h0300, 16'h0400);
    wq.delete();
    axi_wr(`DCD_IDX_EN, 16'h0003);
    hw_req <= 32'h2;
    @(posedge ref_clk);
    hw_req <= 32'h0;
    repeat (40) @(posedge ref_clk);
    chk({16'h0, wq[0][31:16]}, 32'h0200, "channel order");
    chk(32'(wq.size()), 32'h2, "both served");
    axi_wr(`DCD_IDX_CLR, 16'h0003);
    // lock: owner's count runs first, other requests dropped
    cfg(1'b0, 5'd2, 5'b00000, 10'd2, 16'h0110, 16'h0210);
    cfg(1'b1, 5'd3, 5'b00000, 10'd1, 16'h0310, 16'h0410);
    wq.delete();
    axi_wr(`DCD_IDX_EN, 16'h0083);
    hw_req <= 32'h4;
    @(posedge ref_clk);
    hw_req <= 32'h8;
    @(posedge ref_clk);
    hw_req <= 32'h0;
    axi_wr(`DCD_IDX_MODE1, 16'h8300);
    repeat (20) @(posedge ref_clk);
    rd_chk(`DCD_IDX_STAT, 32'h0000_0100, 2'b00);
    chk(32'(wq.size()), 32'h1, "locked out");
    hw_req <= 32'h4;
    @(posedge ref_clk);
    hw_req <= 32'h0;
    repeat (20) @(posedge ref_clk);
    hw_req <= 32'h8;
    @(posedge ref_clk);
    hw_req <= 32'h0;
    repeat (20) @(posedge ref_clk);
    chk(32'(wq.size()), 32'h3, "lock released");
    chk({16'h0, wq[2][31:16]}, 32'h0410, "other channel last");
    rd_chk(`DCD_IDX_STAT, 32'h3, 2'b00);
    axi_wr(`DCD_IDX_CLR, 16'h0003);
    axi_wr(`DCD_IDX_EN, 16'h0000);
    rd_chk(`DCD_IDX_EN, 32'h0, 2'b00);
    print_verdict();
  end
endmodule : tb_dual_channel_sfr_ram_dma
